// ==== rtl/isp_status_top.sv ====
// Purpose: status monitor, prescale select and interrupt gate of the i2c controller
// Assumes: event inputs are one-cycle pulses from the transfer engine
// Notes:   status and control two share one word
`timescale 1ns/1ns
module isp_status_top
   import isp_pkg::*;
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [isp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output      logic                      s_axi_awready,
   input  wire logic [isp_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output      logic                      s_axi_wready,
   output      logic [1:0]                s_axi_bresp,
   output      logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [isp_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output      logic                      s_axi_arready,
   output      logic [isp_pkg::DATA_W-1:0] s_axi_rdata,
   output      logic [1:0]                s_axi_rresp,
   output      logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      start_seen,
   input  wire logic                      stop_seen,
   input  wire logic                      xfer_irq_event,
   input  wire logic                      arb_lost_event,
   input  wire logic                      addr_match_event,
   input  wire logic                      gen_call_event,
   input  wire logic                      rx_bit_strobe,
   input  wire logic                      rx_bit,
   input  wire logic [isp_pkg::SCK_W-1:0] sck_select,
   output      logic                      controller_role,
   output      logic                      direction_transmit,
   output      logic                      bus_busy,
   output      logic                      start_request,
   output      logic                      stop_request,
   output      logic                      i2c_enable,
   output      logic                      prescale_tick,
   output      logic                      scl_ref_tick,
   output      logic                      serial_irq_out
);
   isp_reg_if rif ();

   logic             pend_n;
   logic             arbitration_lost_flag;
   logic             own_address_hit;
   logic             broadcast_call_seen;
   logic             last_rx_bit_value;
   logic [PRS_W-1:0] prs_code;
   logic             irq_unmask;
   logic             raw_irq_flag;
   logic             next_role;
   logic             next_dir;
   logic             next_busy;
   logic             next_pend_n;
   logic             next_arb;
   logic             next_hit;
   logic             next_bcast;
   logic             next_lrb;
   logic [PRS_W-1:0] next_prs_code;
   logic             next_unmask;
   logic             next_raw;
   logic             next_enable;
   logic             next_start_req;
   logic             next_stop_req;
   logic             wr_ctrl;
   logic             wr_prs;
   logic             wr_unmask;
   logic             wr_raw;
   logic [7:0]       wbyte;
   logic [7:0]       status_byte;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and prescaler
   isp_axil_slave u_slave
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rif     (rif)
   );

   isp_prescaler u_prescaler
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .prs_code      (prs_code),
      .sck_select    (sck_select),
      .prescale_tick (prescale_tick),
      .scl_ref_tick  (scl_ref_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode, only the low byte lane carries fields
   assign wbyte     = rif.wr_data[7:0];
   assign wr_ctrl   = rif.wr_stb && rif.wr_strb[0] && (rif.wr_addr == OFS_CTRL_STATUS);
   assign wr_prs    = rif.wr_stb && rif.wr_strb[0] && (rif.wr_addr == OFS_PRESCALE);
   assign wr_unmask = rif.wr_stb && rif.wr_strb[0] && (rif.wr_addr == OFS_UNMASK);
   assign wr_raw    = rif.wr_stb && rif.wr_strb[0] && (rif.wr_addr == OFS_RAW_IRQ);
   assign rif.wr_err = !((rif.wr_addr == OFS_CTRL_STATUS) || (rif.wr_addr == OFS_PRESCALE) ||
                         (rif.wr_addr == OFS_UNMASK) || (rif.wr_addr == OFS_RAW_IRQ));

   always_comb
   begin
      status_byte = '0;
      status_byte[B_ROLE]  = controller_role;
      status_byte[B_DIR]   = direction_transmit;
      status_byte[B_BUSY]  = bus_busy;
      status_byte[B_PEND]  = pend_n;
      status_byte[B_ARB]   = arbitration_lost_flag;
      status_byte[B_HIT]   = own_address_hit;
      status_byte[B_BCAST] = broadcast_call_seen;
      status_byte[B_LRB]   = last_rx_bit_value;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, upper bits read zero
   always_comb
   begin
      rif.rd_data = '0;
      rif.rd_err  = 1'b0;
      unique case (rif.rd_addr)
         OFS_CTRL_STATUS : rif.rd_data[7:0]   = status_byte;
         OFS_PRESCALE    : rif.rd_data[PRS_W-1:0] = prs_code;
         OFS_UNMASK      : rif.rd_data[B_IRQ] = irq_unmask;
         OFS_RAW_IRQ     : rif.rd_data[B_IRQ] = raw_irq_flag;
         default         : rif.rd_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // status, control and interrupt state; engine events win over clears
   always_comb
   begin
      next_role      = controller_role;
      next_dir       = direction_transmit;
      next_busy      = bus_busy;
      next_pend_n    = pend_n;
      next_arb       = arbitration_lost_flag;
      next_hit       = own_address_hit;
      next_bcast     = broadcast_call_seen;
      next_lrb       = last_rx_bit_value;
      next_prs_code  = prs_code;
      next_unmask    = irq_unmask;
      next_raw       = raw_irq_flag;
      next_enable    = i2c_enable;
      next_start_req = 1'b0;
      next_stop_req  = 1'b0;
      if (wr_ctrl)
      begin
         next_role   = wbyte[B_ROLE];
         next_dir    = wbyte[B_DIR];
         next_enable = wbyte[B_ENABLE];
         if (wbyte[B_BUSY])
            next_start_req = 1'b1;
         else
            next_stop_req = 1'b1;
         if (wbyte[B_PEND])
         begin
            next_pend_n = 1'b1;
            next_arb    = 1'b0;
            next_hit    = 1'b0;
            next_bcast  = 1'b0;
         end
      end
      if (wr_prs)
         next_prs_code = wbyte[PRS_W-1:0];
      if (wr_unmask)
         next_unmask = wbyte[B_IRQ];
      if (wr_raw && wbyte[B_IRQ])
         next_raw = 1'b0;
      if (start_seen)
         next_busy = 1'b1;
      else if (stop_seen)
         next_busy = 1'b0;
      if (xfer_irq_event)
      begin
         next_pend_n = 1'b0;
         next_raw    = 1'b1;
      end
      if (arb_lost_event && controller_role)
      begin
         next_arb  = 1'b1;
         next_role = 1'b0;
      end
      if (addr_match_event || gen_call_event)
         next_hit = 1'b1;
      if (gen_call_event)
         next_bcast = 1'b1;
      if (rx_bit_strobe)
         next_lrb = rx_bit;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         controller_role       <= 1'b0;
         direction_transmit    <= 1'b0;
         bus_busy              <= 1'b0;
         pend_n                <= PEND_RST;
         arbitration_lost_flag <= 1'b0;
         own_address_hit       <= 1'b0;
         broadcast_call_seen   <= 1'b0;
         last_rx_bit_value     <= 1'b0;
         prs_code              <= PRS_RST;
         irq_unmask            <= UNMASK_RST;
         raw_irq_flag          <= 1'b0;
         i2c_enable            <= 1'b0;
         start_request         <= 1'b0;
         stop_request          <= 1'b0;
      end
      else
      begin
         controller_role       <= next_role;
         direction_transmit    <= next_dir;
         bus_busy              <= next_busy;
         pend_n                <= next_pend_n;
         arbitration_lost_flag <= next_arb;
         own_address_hit       <= next_hit;
         broadcast_call_seen   <= next_bcast;
         last_rx_bit_value     <= next_lrb;
         prs_code              <= next_prs_code;
         irq_unmask            <= next_unmask;
         raw_irq_flag          <= next_raw;
         i2c_enable            <= next_enable;
         start_request         <= next_start_req;
         stop_request          <= next_stop_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt output
   assign serial_irq_out = raw_irq_flag && irq_unmask;
endmodule // isp_status_top

// ==== rtl/isp_pkg.sv ====
// Purpose: constants for the i2c status, prescale and interrupt block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   register map, field positions and reset values live here
//
// Behaviour
// - status read, control two write, same word
// - status bit 5 shows bus busy
// - bit 4 low while interrupt pending, resets high
// - address hit also on broadcast; broadcast only broadcast
// - bit 0 holds last received data bit
// - prescale code 0 divides 32, else n
// - unmask bit gates interrupt output, resets 0
// - raw interrupt flag shown before masking
// - prescaled clock divided by 2^(n+2)+16 is serial clock reference
package isp_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          PRS_W           = 5;
   localparam int          SCK_W           = 3;
   localparam int          DIV_W           = 6;
   localparam int          SPAN_W          = 10;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0]  OFS_PRESCALE    = 8'h04;
   localparam logic [7:0]  OFS_UNMASK      = 8'h08;
   localparam logic [7:0]  OFS_RAW_IRQ     = 8'h0C;
   // status and control two bit positions
   localparam int          B_ROLE          = 7;
   localparam int          B_DIR           = 6;
   localparam int          B_BUSY          = 5;
   localparam int          B_PEND          = 4;
   localparam int          B_ARB           = 3;
   localparam int          B_ENABLE        = 3;
   localparam int          B_HIT           = 2;
   localparam int          B_BCAST         = 1;
   localparam int          B_LRB           = 0;
   localparam int          B_IRQ           = 0;
   // reset values
   localparam logic        PEND_RST        = 1'b1;
   localparam logic [4:0]  PRS_RST         = 5'h00;
   localparam logic        UNMASK_RST      = 1'b0;
   // prescale decode
   localparam logic [4:0]  PRS_CODE_32     = 5'h00;
   localparam logic [5:0]  PRS_DIV_32      = 6'h20;
   localparam logic [9:0]  SPAN_BASE       = 10'h010;
   localparam logic [1:0]  SPAN_SHIFT_ADD  = 2'h2;
   // axi responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ==== rtl/isp_reg_if.sv ====
// Purpose: register access carrier between the bus slave and the register file
// Assumes: one write strobe and one read lookup per transfer
// Notes:   read data is combinational from the address
`timescale 1ns/1ns
interface isp_reg_if;
   import isp_pkg::*;
   logic              wr_stb;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_err;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_err;
   modport bus  (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
   modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface // isp_reg_if

// ==== rtl/isp_axil_slave.sv ====
// Purpose: AXI4-Lite slave front end
// Assumes: one write and one read under way at most
// Notes:   address and data taken in either order
`timescale 1ns/1ns
module isp_axil_slave
   import isp_pkg::*;
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [isp_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                      awvalid,
   output      logic                      awready,
   input  wire logic [isp_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output      logic                      wready,
   output      logic [1:0]                bresp,
   output      logic                      bvalid,
   input  wire logic                      bready,
   input  wire logic [isp_pkg::ADDR_W-1:0] araddr,
   input  wire logic                      arvalid,
   output      logic                      arready,
   output      logic [isp_pkg::DATA_W-1:0] rdata,
   output      logic [1:0]                rresp,
   output      logic                      rvalid,
   input  wire logic                      rready,
   isp_reg_if.bus                         rif
);
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_q;
   logic [DATA_W-1:0] w_q;
   logic [3:0]        s_q;
   logic              next_aw_held;
   logic              next_w_held;
   logic [ADDR_W-1:0] next_aw_q;
   logic [DATA_W-1:0] next_w_q;
   logic [3:0]        next_s_q;
   logic [1:0]        next_bresp;
   logic              next_bvalid;
   logic [DATA_W-1:0] next_rdata;
   logic [1:0]        next_rresp;
   logic              next_rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // handshakes and register access
   assign awready     = !aw_held && !bvalid;
   assign wready      = !w_held && !bvalid;
   assign arready     = !rvalid;
   assign rif.wr_stb  = aw_held && w_held && !bvalid;
   assign rif.wr_addr = aw_q;
   assign rif.wr_data = w_q;
   assign rif.wr_strb = s_q;
   assign rif.rd_addr = araddr;

   ////////////////////////////////////////////////////////////////////////////
   // write and read channel state
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_q    = aw_q;
      next_w_q     = w_q;
      next_s_q     = s_q;
      next_bresp   = bresp;
      next_bvalid  = bvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      next_rvalid  = rvalid;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_aw_q    = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_w_q    = wdata;
         next_s_q    = wstrb;
      end
      if (rif.wr_stb)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && bready)
         next_bvalid = 1'b0;
      if (arvalid && arready)
      begin
         next_rvalid = 1'b1;
         next_rdata  = rif.rd_data;
         next_rresp  = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= '0;
         w_q     <= '0;
         s_q     <= '0;
         bresp   <= RESP_OKAY;
         bvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_q    <= next_aw_q;
         w_q     <= next_w_q;
         s_q     <= next_s_q;
         bresp   <= next_bresp;
         bvalid  <= next_bvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
         rvalid  <= next_rvalid;
      end
   end
endmodule // isp_axil_slave

// ==== rtl/isp_prescaler.sv ====
// Purpose: prescaler tick and serial clock reference tick
// Assumes: code and select held steady during a transfer
// Notes:   scl reference period is p * (2^(n+2)+16) system clocks
`timescale 1ns/1ns
module isp_prescaler
   import isp_pkg::*;
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [isp_pkg::PRS_W-1:0] prs_code,
   input  wire logic [isp_pkg::SCK_W-1:0] sck_select,
   output      logic                     prescale_tick,
   output      logic                     scl_ref_tick
);
   logic [DIV_W-1:0]  prs_cnt;
   logic [SPAN_W-1:0] span_cnt;
   logic [DIV_W-1:0]  next_prs_cnt;
   logic [SPAN_W-1:0] next_span_cnt;
   logic              next_prescale_tick;
   logic              next_scl_ref_tick;

   // code 0 means 32, any other code n means n
   function automatic logic [DIV_W-1:0] prs_divisor(input logic [PRS_W-1:0] code);
      prs_divisor = (code == PRS_CODE_32) ? PRS_DIV_32 : {1'b0, code};
   endfunction

   function automatic logic [SPAN_W-1:0] sck_span(input logic [SCK_W-1:0] n);
      sck_span = (SPAN_W'(1) << ({1'b0, n} + {2'b00, SPAN_SHIFT_ADD})) + SPAN_BASE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // two stage divider
   always_comb
   begin
      next_prs_cnt       = prs_cnt + DIV_W'(1);
      next_span_cnt      = span_cnt;
      next_prescale_tick = 1'b0;
      next_scl_ref_tick  = 1'b0;
      if (next_prs_cnt >= prs_divisor(prs_code))
      begin
         next_prs_cnt       = '0;
         next_prescale_tick = 1'b1;
         next_span_cnt      = span_cnt + SPAN_W'(1);
         if (next_span_cnt >= sck_span(sck_select))
         begin
            next_span_cnt     = '0;
            next_scl_ref_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prs_cnt       <= '0;
         span_cnt      <= '0;
         prescale_tick <= 1'b0;
         scl_ref_tick  <= 1'b0;
      end
      else
      begin
         prs_cnt       <= next_prs_cnt;
         span_cnt      <= next_span_cnt;
         prescale_tick <= next_prescale_tick;
         scl_ref_tick  <= next_scl_ref_tick;
      end
   end
endmodule // isp_prescaler

// ==== sim/isp_status_props.sv ====
// Purpose: port assertions for the status block
// Assumes: one clock, aresetn synchronous active low
// Notes:   bound to isp_status_top
`timescale 1ns/1ns
module isp_status_props
   import isp_pkg::*;
(
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic                       s_axi_rvalid,
   input wire logic [isp_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic                       start_seen,
   input wire logic                       stop_seen,
   input wire logic                       xfer_irq_event,
   input wire logic                       arb_lost_event,
   input wire logic                       controller_role,
   input wire logic                       bus_busy,
   input wire logic                       start_request,
   input wire logic                       serial_irq_out
);
   import isp_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer;
      $rose(s_axi_bvalid);
   endsequence
   ////////////////////////////////////////
   chk_busy_start: assert property (start_seen |=> bus_busy) else $error("busy not set");
   chk_busy_stop: assert property (stop_seen && !start_seen |=> !bus_busy) else $error("busy not freed");
   chk_busy_hold: assert property (!start_seen && !stop_seen |=> $stable(bus_busy)) else $error("busy moved");
   chk_role_lost: assert property (arb_lost_event && controller_role |=> !controller_role) else $error("role kept");
   chk_wr_answer: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
   chk_irq_rise: assert property ($rose(serial_irq_out) |-> $past(xfer_irq_event) or wr_answer) else $error("irq rose");
   chk_irq_fall: assert property ($fell(serial_irq_out) |-> wr_answer) else $error("irq fell alone");
   chk_start_pulse: assert property (start_request |=> !start_request) else $error("start request stuck");
endmodule // isp_status_props
bind isp_status_top isp_status_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .start_seen(start_seen), .stop_seen(stop_seen),
   .xfer_irq_event(xfer_irq_event), .arb_lost_event(arb_lost_event), .controller_role(controller_role),
   .bus_busy(bus_busy), .start_request(start_request), .serial_irq_out(serial_irq_out));

// ==== sim/isp_bus_partner.sv ====
// Purpose: far side of the serial bus, as seen by the status block
// Assumes: events are one-cycle pulses
// Notes:   ev bits start, stop, irq, arb, addr, gcall, rx strobe
`timescale 1ns/1ns
module isp_bus_partner
(
   input  wire logic       aclk,
   output      logic [6:0] ev,
   output      logic       rx_bit
);
   initial
   begin
      ev = 7'h00;
      rx_bit = 1'b0;
   end
   ////////////////////////////////////////
   // data line shows the inverse once the strobe is gone
   task automatic pulse(input int k, input logic b);
      @(posedge aclk);
      ev[k] <= 1'b1;
      rx_bit <= b;
      @(posedge aclk);
      ev <= 7'h00;
      rx_bit <= ~b;
   endtask
endmodule // isp_bus_partner

// ==== sim/isp_status_top_tb.sv ====
// Purpose: self-checking bench for isp_status_top
// Assumes: AXI4-Lite master in the bench, partner drives events
// Notes:   register rows first, then prescale, reset and event cases
`timescale 1ns/1ns
module isp_status_top_tb;
   import isp_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} isp_row_t;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, q, rdata;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [2:0]  sck = 3'h0;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, role, busy, ptick, stick, irq, rx_bit, en;
   logic [6:0]  ev;
   int          err_total = 0, n_tests = 0, g, i;
   logic [31:0] pcode [3] = '{32'h0, 32'h5, 32'h1};
   int          pdiv [3] = '{32, 5, 1};
   isp_row_t    rows [6] = '{'{OFS_PRESCALE, 32'h1, 32'h1, RESP_OKAY}, '{OFS_PRESCALE, 32'hFFFFFFFF, 32'h1F, RESP_OKAY},
      '{OFS_UNMASK, 32'hFFFFFFFF, 32'h1, RESP_OKAY}, '{OFS_UNMASK, 32'h0, 32'h0, RESP_OKAY},
      '{8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR}, '{OFS_CTRL_STATUS, 32'hE8, 32'hD0, RESP_OKAY}};
   isp_status_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_seen(ev[0]), .stop_seen(ev[1]),
      .xfer_irq_event(ev[2]), .arb_lost_event(ev[3]), .addr_match_event(ev[4]), .gen_call_event(ev[5]),
      .rx_bit_strobe(ev[6]), .rx_bit(rx_bit), .sck_select(sck), .controller_role(role),
      .direction_transmit(), .bus_busy(busy), .start_request(), .stop_request(), .i2c_enable(en),
      .prescale_tick(ptick), .scl_ref_tick(stick), .serial_irq_out(irq));
   isp_bus_partner u_bus (.aclk(aclk), .ev(ev), .rx_bit(rx_bit));
   initial
   begin
      forever #5 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic close_out;
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bail;
      err_total++;
      $display("CHECK FAILED at %0t: no answer", $time);
      close_out();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) bail();
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) bail();
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic ev_chk(input int k, input logic b, input logic [31:0] exp);
      u_bus.pulse(k, b);
      rd(OFS_CTRL_STATUS, q, r);
      chk(q, exp);
      chk({29'h0, en, role, busy}, {29'h0, 1'b0, exp[7], exp[5]});
   endtask
   task automatic gap(input logic scl, output int gv);
      int n, k;
      for (k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge aclk);
            n++;
         end
         while ((scl ? stick : ptick) !== 1'b1 && n < 3000);
         if (n >= 3000) bail();
      end
      gv = n;
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++)
      begin
         wr(rows[i].a, rows[i].d, r);
         chk({30'h0, r}, {30'h0, rows[i].r});
         rd(rows[i].a, q, r);
         chk(q, rows[i].q);
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      chk({31'h0, en}, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         wr(OFS_PRESCALE, pcode[i], r);
         sck <= 3'(7 * i / 2);
         gap(1'b0, g);
         chk(g, pdiv[i]);
         gap(1'b1, g);
         chk(g, pdiv[i] * ((1 << (7 * i / 2 + 2)) + 16));
      end
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         rd(8'(4 * i), q, r);
         chk(q, (i == 0) ? 32'h10 : 32'h0);
      end
      ev_chk(4, 1'b0, 32'h14);
      ev_chk(5, 1'b0, 32'h16);
      wr(OFS_CTRL_STATUS, 32'h10, r);
      ev_chk(5, 1'b0, 32'h16);
      ev_chk(6, 1'b1, 32'h17);
      ev_chk(6, 1'b0, 32'h16);
      ev_chk(0, 1'b0, 32'h36);
      ev_chk(1, 1'b0, 32'h16);
      ev_chk(3, 1'b0, 32'h16);
      wr(OFS_CTRL_STATUS, 32'h90, r);
      ev_chk(3, 1'b0, 32'h18);
      ev_chk(2, 1'b0, 32'h08);
      rd(OFS_RAW_IRQ, q, r);
      chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_UNMASK, 32'h1, r);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_RAW_IRQ, 32'h1, r);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_CTRL_STATUS, q, r);
      chk(q, 32'h08);
      wr(OFS_CTRL_STATUS, 32'h10, r);
      rd(OFS_CTRL_STATUS, q, r);
      chk(q, 32'h10);
      close_out();
   end
endmodule // isp_status_top_tb
